// >>> core/sam_pkg.sv
// package of constants and types for the servo alarm monitor register bank
package sam_pkg;
    // ==========================================
    // register map (word offsets are byte addresses)
    localparam logic [7:0] SAM_ADDR_FW_VERSION = 8'h00;
    localparam logic [7:0] SAM_ADDR_ALARM_CODE = 8'h02;
    localparam logic [7:0] SAM_ADDR_MON_SELECT = 8'h04;
    localparam logic [7:0] SAM_ADDR_HIST_BASE = 8'h08;
    localparam logic [7:0] SAM_ADDR_INT_STATUS = 8'h24;
    localparam logic [7:0] SAM_ADDR_INT_MASK = 8'h28;
    localparam logic [7:0] SAM_ADDR_CONFIG = 8'h1c;
    localparam logic [7:0] SAM_ADDR_PENDING = 8'h20;
    localparam logic [7:0] SAM_ADDR_HIST_STEP = 8'h04;
    localparam int SAM_HIST_DEPTH = 5;
    // ==========================================
    // reset values and monitor select range limits
    localparam logic [15:0] SAM_MON_SELECT_RST = 16'h0000;
    localparam logic [15:0] SAM_CONFIG_RST = 16'h0000;
    localparam logic [15:0] SAM_MON_MIN = 16'hff90; // -112
    localparam logic [15:0] SAM_MON_MAX = 16'h006f; // 111
    // ==========================================
    // alarm codes, three-digit bcd
    localparam logic [15:0] SAM_ALM_NONE = 16'h0000;
    localparam logic [15:0] SAM_ALM_OVER_CURRENT = 16'h0001;
    localparam logic [15:0] SAM_ALM_OVER_VOLTAGE = 16'h0002;
    localparam logic [15:0] SAM_ALM_UNDER_VOLTAGE = 16'h0003;
    localparam logic [15:0] SAM_ALM_OVERLOAD = 16'h0006;
    localparam logic [15:0] SAM_ALM_OVER_SPEED = 16'h0007;
    localparam logic [15:0] SAM_ALM_ENCODER = 16'h0011;
    localparam logic [15:0] SAM_ALM_EMERG_STOP = 16'h0013;
    localparam logic [15:0] SAM_ALM_SERIAL_ERR = 16'h0019;
    localparam logic [15:0] SAM_ALM_SERIAL_TMO = 16'h0020;
    localparam logic [15:0] SAM_ALM_FW_UPGRADE = 16'h0099;
    // interrupt status bits
    localparam int SAM_IRQ_NEW_ALARM = 0;
    localparam int SAM_IRQ_CLEARED = 1;
    localparam int SAM_IRQ_WR_REJECT = 2;
    localparam int SAM_IRQ_BITS = 3;
    // config register bit: under-voltage also when servo off
    localparam int SAM_CFG_UV_ALWAYS = 0;
    // ==========================================
    // fault input vector, one bit per source
    typedef struct packed {
        logic fw_upgrade;
        logic over_current;
        logic over_voltage;
        logic encoder;
        logic emerg_stop;
        logic over_speed;
        logic overload;
        logic under_voltage;
        logic serial_tmo;
        logic serial_err;
    } sam_faults_t;
    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } sam_bus_req_t;
endpackage : sam_pkg

// >>> core/sam_sync.sv
// two-flop synchroniser vector for pin inputs
`timescale 1ns/1ps
module sam_sync import sam_pkg::*; #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk, // system clock
    input wire logic i_reset_n, // sync reset, active low
    input wire logic [WIDTH-1:0] i_async, // pin levels
    output logic [WIDTH-1:0] o_sync // synchronised levels
);
    logic [WIDTH-1:0] meta_reg;
    // ==========================================
    // two stages per bit
    genvar g;
    for (g = 0; g < WIDTH; g++) begin : g_bit
        always_ff @(posedge i_clk) begin
            if (!i_reset_n) begin
                meta_reg[g] <= 1'b0;
                o_sync[g] <= 1'b0;
            end else begin
                meta_reg[g] <= i_async[g];
                o_sync[g] <= meta_reg[g];
            end
        end
    end
endmodule : sam_sync

// >>> core/sam_alarm_encode.sv
// priority encoder from fault sources to alarm code
`timescale 1ns/1ps
module sam_alarm_encode import sam_pkg::*; (
    input wire sam_faults_t i_faults, // synchronised fault levels
    input wire logic i_servo_on, // servo enabled
    input wire logic i_uv_always, // under-voltage also when off
    output logic [15:0] o_code // highest priority alarm code
);
    // ==========================================
    // highest priority first, upgrade overrides all
    always_comb begin
        o_code = SAM_ALM_NONE;
        if (i_faults.fw_upgrade) begin
            o_code = SAM_ALM_FW_UPGRADE;
        end else if (i_faults.over_current) begin
            o_code = SAM_ALM_OVER_CURRENT;
        end else if (i_faults.over_voltage) begin
            o_code = SAM_ALM_OVER_VOLTAGE;
        end else if (i_faults.under_voltage && (i_servo_on || i_uv_always)) begin
            o_code = SAM_ALM_UNDER_VOLTAGE;
        end else if (i_faults.encoder) begin
            o_code = SAM_ALM_ENCODER;
        end else if (i_faults.emerg_stop) begin
            o_code = SAM_ALM_EMERG_STOP;
        end else if (i_faults.overload) begin
            o_code = SAM_ALM_OVERLOAD;
        end else if (i_faults.over_speed) begin
            o_code = SAM_ALM_OVER_SPEED;
        end else if (i_faults.serial_err) begin
            o_code = SAM_ALM_SERIAL_ERR;
        end else if (i_faults.serial_tmo) begin
            o_code = SAM_ALM_SERIAL_TMO;
        end
    end
endmodule : sam_alarm_encode

// >>> core/sam_regs.sv
// servo alarm and monitor register bank, top module
// ==========================================
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module sam_regs import sam_pkg::*; #(
    parameter logic [15:0] FW_VERSION = 16'h0064 // arbitrary version value
) (
    input wire logic i_clk, // 200 mhz clock
    input wire logic i_reset_n, // sync reset, active low
    input wire logic [7:0] i_addr, // register byte address
    input wire logic [15:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [15:0] o_rdata, // read data, cycle after strobe
    input wire sam_faults_t i_faults, // fault pins
    input wire logic i_servo_on, // servo enabled pin
    input wire logic i_alarm_reset_input, // alarm reset digital input
    input wire logic i_power_restart, // restart pulse from logic
    output logic [15:0] o_alarm_code, // current alarm code
    output logic o_alarm_active, // an alarm is latched
    output logic [15:0] o_panel_monitor_select, // active monitor variable
    output logic o_irq // level interrupt
);
    // ==========================================
    // synchronisers for pins
    localparam int SYNC_W = $bits(sam_faults_t) + 2;
    logic [SYNC_W-1:0] sync_out;
    sam_faults_t faults_s;
    logic servo_on_s;
    logic alarm_reset_input_s;

    sam_sync #(.WIDTH(SYNC_W)) u_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_async({i_faults, i_servo_on, i_alarm_reset_input}),
        .o_sync(sync_out)
    );
    assign faults_s = sync_out[SYNC_W-1:2];
    assign servo_on_s = sync_out[1];
    assign alarm_reset_input_s = sync_out[0];

    // ==========================================
    // registers and state
    logic [15:0] alarm_reg;
    logic [15:0] mon_sel_reg;
    logic [15:0] cfg_pending_reg;
    logic [15:0] cfg_reg;
    logic [15:0] hist_reg [SAM_HIST_DEPTH];
    logic [SAM_IRQ_BITS-1:0] stat_reg;
    logic [SAM_IRQ_BITS-1:0] mask_reg;
    logic [15:0] rdata_reg;
    logic alarm_reset_input_d_reg;
    logic [15:0] live_code;
    sam_bus_req_t req;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    sam_alarm_encode u_enc (
        .i_faults(faults_s),
        .i_servo_on(servo_on_s),
        .i_uv_always(cfg_reg[SAM_CFG_UV_ALWAYS]),
        .o_code(live_code)
    );

    // ==========================================
    // decode of write actions
    logic wr_alarm;
    logic wr_mon;
    logic wr_pend;
    logic clear_req;
    logic mon_in_range;
    logic wr_reject;
    logic new_fault;
    logic alarm_cleared;

    assign wr_alarm = req.wr && (req.addr == SAM_ADDR_ALARM_CODE);
    assign wr_mon = req.wr && (req.addr == SAM_ADDR_MON_SELECT);
    assign wr_pend = req.wr && (req.addr == SAM_ADDR_PENDING);
    // zero write or rising reset input both clear
    assign clear_req = (wr_alarm && (req.wdata == SAM_ALM_NONE))
        || (alarm_reset_input_s && !alarm_reset_input_d_reg);
    // accepted monitor values: -112 or 0..111
    assign mon_in_range = (req.wdata == SAM_MON_MIN)
        || (req.wdata <= SAM_MON_MAX);
    // writes dropped: nonzero alarm, read-only words, bad range, locked
    assign wr_reject = (wr_alarm && (req.wdata != SAM_ALM_NONE))
        || (req.wr && (req.addr == SAM_ADDR_FW_VERSION))
        || (req.wr && (req.addr >= SAM_ADDR_HIST_BASE)
            && (req.addr < SAM_ADDR_CONFIG))
        || (wr_mon && !mon_in_range)
        || (wr_pend && servo_on_s);
    // a fault is new when latched code is empty and one is live
    assign new_fault = (live_code != SAM_ALM_NONE) && (alarm_reg == SAM_ALM_NONE);
    assign alarm_cleared = clear_req && (alarm_reg != SAM_ALM_NONE)
        && (live_code == SAM_ALM_NONE);

    // ==========================================
    // alarm reset input edge history
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            alarm_reset_input_d_reg <= 1'b0;
        end else begin
            alarm_reset_input_d_reg <= alarm_reset_input_s;
        end
    end

    // ==========================================
    // latched alarm code, cleared only when cause is gone
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            alarm_reg <= SAM_ALM_NONE;
        end else if (live_code == SAM_ALM_FW_UPGRADE) begin
            alarm_reg <= SAM_ALM_FW_UPGRADE;
        end else if (new_fault) begin
            alarm_reg <= live_code;
        end else if (clear_req && live_code == SAM_ALM_NONE) begin
            alarm_reg <= SAM_ALM_NONE;
        end
    end

    // ==========================================
    // fault history shift on each new fault
    genvar h;
    for (h = 0; h < SAM_HIST_DEPTH; h++) begin : g_hist
        always_ff @(posedge i_clk) begin
            if (!i_reset_n) begin
                hist_reg[h] <= SAM_ALM_NONE;
            end else if (new_fault) begin
                if (h == 0) begin
                    hist_reg[h] <= live_code;
                end else begin
                    hist_reg[h] <= hist_reg[h-1];
                end
            end
        end
    end

    // ==========================================
    // monitor select, range checked
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            mon_sel_reg <= SAM_MON_SELECT_RST;
        end else if (wr_mon && mon_in_range) begin
            mon_sel_reg <= req.wdata;
        end
    end

    // ==========================================
    // config: pending written while off, applied on restart
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cfg_pending_reg <= SAM_CONFIG_RST;
        end else if (wr_pend && !servo_on_s) begin
            cfg_pending_reg <= req.wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cfg_reg <= SAM_CONFIG_RST;
        end else if (i_power_restart) begin
            cfg_reg <= cfg_pending_reg;
        end
    end

    // ==========================================
    // interrupt mask
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            mask_reg <= '0;
        end else if (req.wr && req.addr == SAM_ADDR_INT_MASK) begin
            mask_reg <= req.wdata[SAM_IRQ_BITS-1:0];
        end
    end

    // ==========================================
    // sticky status, set wins over write-one clear
    logic [SAM_IRQ_BITS-1:0] stat_set;
    logic [SAM_IRQ_BITS-1:0] stat_clr;
    always_comb begin
        stat_set = '0;
        stat_set[SAM_IRQ_NEW_ALARM] = new_fault;
        stat_set[SAM_IRQ_CLEARED] = alarm_cleared;
        stat_set[SAM_IRQ_WR_REJECT] = wr_reject;
        stat_clr = '0;
        if (req.wr && req.addr == SAM_ADDR_INT_STATUS) begin
            stat_clr = req.wdata[SAM_IRQ_BITS-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            stat_reg <= '0;
        end else begin
            stat_reg <= (stat_reg & ~stat_clr) | stat_set;
        end
    end

    // ==========================================
    // read data, valid the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rdata_reg <= '0;
        end else if (req.rd) begin
            case (req.addr)
                SAM_ADDR_FW_VERSION: rdata_reg <= FW_VERSION;
                SAM_ADDR_ALARM_CODE: rdata_reg <= alarm_reg;
                SAM_ADDR_MON_SELECT: rdata_reg <= mon_sel_reg;
                SAM_ADDR_HIST_BASE: rdata_reg <= hist_reg[0];
                SAM_ADDR_HIST_BASE + SAM_ADDR_HIST_STEP: rdata_reg <= hist_reg[1];
                SAM_ADDR_HIST_BASE + 8'h08: rdata_reg <= hist_reg[2];
                SAM_ADDR_HIST_BASE + 8'h0c: rdata_reg <= hist_reg[3];
                SAM_ADDR_HIST_BASE + 8'h10: rdata_reg <= hist_reg[4];
                SAM_ADDR_INT_STATUS: rdata_reg <= {13'h0000, stat_reg};
                SAM_ADDR_INT_MASK: rdata_reg <= {13'h0000, mask_reg};
                SAM_ADDR_CONFIG: rdata_reg <= cfg_reg;
                SAM_ADDR_PENDING: rdata_reg <= cfg_pending_reg;
                default: rdata_reg <= '0; // unmapped reads zero
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    // ==========================================
    // registered outputs
    logic irq_reg;
    logic irq_alarm_active;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |((stat_reg & ~stat_clr | stat_set) & mask_reg);
        end
    end

    assign o_rdata = rdata_reg;
    assign o_alarm_code = alarm_reg;
    assign o_alarm_active = irq_alarm_active;
    assign o_panel_monitor_select = mon_sel_reg;
    assign o_irq = irq_reg;

    // alarm active flag
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            irq_alarm_active <= 1'b0;
        end else begin
            irq_alarm_active <= (alarm_reg != SAM_ALM_NONE);
        end
    end
endmodule : sam_regs

// >>> testbench/sam_regs_properties.sv
// port checks for the alarm monitor register bank
`timescale 1ns/1ps
module sam_regs_properties import sam_pkg::*; #(
    parameter logic [15:0] FW_VERSION = 16'h0064 // arbitrary version value
) (
    input wire logic i_clk, // clock
    input wire logic i_reset_n, // reset
    input wire logic [7:0] i_addr, // address
    input wire logic [15:0] i_wdata, // write data
    input wire logic i_wr, // write
    input wire logic i_rd, // read
    input wire logic [15:0] o_rdata, // read data
    input wire sam_faults_t i_faults, // fault pins
    input wire logic i_servo_on, // servo on
    input wire logic i_alarm_reset_input, // reset pin
    input wire logic i_power_restart, // restart
    input wire logic [15:0] o_alarm_code, // alarm
    input wire logic o_alarm_active, // alarm flag
    input wire logic [15:0] o_panel_monitor_select, // monitor
    input wire logic o_irq // interrupt
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    // ==========================================
    // named steps
    sequence s_rd_alarm;
        i_rd && i_addr == SAM_ADDR_ALARM_CODE;
    endsequence
    sequence s_upgrade_held;
        i_faults.fw_upgrade [*4];
    endsequence
    sequence s_encoder_only;
        (o_alarm_code == 16'h0000 && i_faults == 10'h040) ##1 (i_faults == 10'h040) [*3];
    endsequence
    // ==========================================
    // checks
    a_fw_read:
        assert property (i_rd && i_addr == 8'h00 |=> o_rdata == FW_VERSION) else $error("bad fw");
    a_alarm_read:
        assert property (s_rd_alarm |=> o_rdata == $past(o_alarm_code)) else $error("bad alarm");
    a_upgrade_code:
        assert property (s_upgrade_held |-> o_alarm_code == 16'h0099) else $error("no 099");
    a_encoder_code:
        assert property (s_encoder_only |-> o_alarm_code == 16'h0011) else $error("no 011");
    a_mon_accept:
        assert property (i_wr && i_addr == SAM_ADDR_MON_SELECT
            && (i_wdata <= SAM_MON_MAX || i_wdata == SAM_MON_MIN)
            |=> o_panel_monitor_select == $past(i_wdata)) else $error("mon dropped");
    a_mon_reject:
        assert property (i_wr && i_addr == SAM_ADDR_MON_SELECT
            && !(i_wdata <= SAM_MON_MAX || i_wdata == SAM_MON_MIN)
            |=> $stable(o_panel_monitor_select)) else $error("mon taken");
    a_nonzero_kept:
        assert property (i_wr && i_addr == SAM_ADDR_ALARM_CODE && i_wdata != 16'h0000
            && o_alarm_code != 16'h0000 && !i_faults.fw_upgrade
            |=> $stable(o_alarm_code)) else $error("alarm written");
    a_active_flag:
        assert property (o_alarm_active == ($past(o_alarm_code) != 16'h0000))
            else $error("bad flag");
endmodule : sam_regs_properties

bind sam_regs sam_regs_properties #(.FW_VERSION(FW_VERSION)) sam_regs_properties_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_faults(i_faults),
    .i_servo_on(i_servo_on), .i_alarm_reset_input(i_alarm_reset_input),
    .i_power_restart(i_power_restart), .o_alarm_code(o_alarm_code),
    .o_alarm_active(o_alarm_active), .o_panel_monitor_select(o_panel_monitor_select),
    .o_irq(o_irq)
);

// >>> testbench/sam_host_model.sv
// host controller model driving the register port
`timescale 1ns/1ps
module sam_host_model import sam_pkg::*; (
    input wire logic i_clk, // clock
    input wire logic [15:0] i_rdata, // read data
    output sam_bus_req_t o_req // bus request
);
    initial o_req = '0;
    // one-cycle write, also clears alarm or picks monitor
    task automatic write(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        o_req <= '0;
    endtask : write
    // one-cycle read, data taken the cycle after
    task automatic read(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_clk);
        o_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        o_req <= '0;
        // data stands until the next edge; take it mid-cycle
        @(negedge i_clk);
        d = i_rdata;
    endtask : read
endmodule : sam_host_model

// >>> testbench/sam_regs_bench.sv
// self-checking bench for the alarm monitor register bank
`timescale 1ns/1ps
module sam_regs_bench import sam_pkg::*; ;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    sam_bus_req_t req;
    sam_faults_t faults = '0;
    logic servo_on = 1'b0;
    logic alarm_reset_input = 1'b0;
    logic restart = 1'b0;
    logic [15:0] rdata, alarm_code, mon_sel;
    logic alarm_active, irq;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    // alarm code per fault bit, lsb first
    logic [15:0] codes [10] = '{16'h0019, 16'h0020, 16'h0003, 16'h0006, 16'h0007,
        16'h0013, 16'h0011, 16'h0002, 16'h0001, 16'h0099};
    logic [15:0] mon_w [5] = '{16'h006f, 16'h0070, 16'hff90, 16'hff8f, 16'h0000};
    logic [15:0] mon_e [5] = '{16'h006f, 16'h006f, 16'hff90, 16'hff90, 16'h0000};
    always #2.5 i_clk = ~i_clk;
    sam_host_model sam_host_model_i (.i_clk(i_clk), .i_rdata(rdata), .o_req(req));
    sam_regs sam_regs_i (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(req.addr), .i_wdata(req.wdata),
        .i_wr(req.wr), .i_rd(req.rd), .o_rdata(rdata), .i_faults(faults),
        .i_servo_on(servo_on), .i_alarm_reset_input(alarm_reset_input), .i_power_restart(restart),
        .o_alarm_code(alarm_code), .o_alarm_active(alarm_active),
        .o_panel_monitor_select(mon_sel), .o_irq(irq)
    );
    // ==========================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        sam_host_model_i.read(a, d);
        chk(d, exp);
        @(posedge i_clk);
    endtask : rdc
    task automatic pulse_restart;
        restart <= 1'b1;
        tick(1);
        restart <= 1'b0;
        tick(2);
    endtask : pulse_restart
    task automatic conclude;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    // hang guard
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            conclude();
        end
    end
    // ==========================================
    // main sequence
    initial begin
        tick(8);
        i_reset_n <= 1'b1;
        rdc(SAM_ADDR_FW_VERSION, 16'h0064);
        rdc(SAM_ADDR_MON_SELECT, 16'h0000);
        sam_host_model_i.write(SAM_ADDR_INT_MASK, 16'h0007);
        sam_host_model_i.write(SAM_ADDR_FW_VERSION, 16'h1234);
        rdc(SAM_ADDR_FW_VERSION, 16'h0064);
        chk({15'h0000, irq}, 16'h0001);
        sam_host_model_i.write(SAM_ADDR_INT_STATUS, 16'h0007);
        tick(2);
        chk({15'h0000, irq}, 16'h0000);
        // monitor select range edges
        for (int k = 0; k < 5; k++) begin
            sam_host_model_i.write(SAM_ADDR_MON_SELECT, mon_w[k]);
            rdc(SAM_ADDR_MON_SELECT, mon_e[k]);
        end
        chk(mon_sel, 16'h0000);
        // every fault source alone, cleared by write or pin
        servo_on <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            faults <= sam_faults_t'(10'h001 << i);
            tick(5);
            chk(alarm_code, codes[i]);
            chk({15'h0000, alarm_active}, 16'h0001);
            sam_host_model_i.write(SAM_ADDR_ALARM_CODE, 16'hffff);
            sam_host_model_i.write(SAM_ADDR_ALARM_CODE, 16'h0000);
            rdc(SAM_ADDR_ALARM_CODE, codes[i]);
            rdc(SAM_ADDR_HIST_BASE, codes[i]);
            if (i > 0) rdc(SAM_ADDR_HIST_BASE + SAM_ADDR_HIST_STEP, codes[i-1]);
            faults <= '0;
            tick(4);
            if (i % 2 == 1) begin
                alarm_reset_input <= 1'b1;
                tick(4);
                alarm_reset_input <= 1'b0;
            end else begin
                sam_host_model_i.write(SAM_ADDR_ALARM_CODE, 16'h0000);
            end
            tick(4);
            chk(alarm_code, 16'h0000);
            chk({15'h0000, alarm_active}, 16'h0000);
        end
        // settings locked while enabled, applied after restart
        sam_host_model_i.write(SAM_ADDR_PENDING, 16'h0001);
        servo_on <= 1'b0;
        faults <= 10'h004;
        pulse_restart();
        rdc(SAM_ADDR_CONFIG, 16'h0000);
        chk(alarm_code, 16'h0000);
        sam_host_model_i.write(SAM_ADDR_PENDING, 16'h0001);
        rdc(SAM_ADDR_CONFIG, 16'h0000);
        pulse_restart();
        rdc(SAM_ADDR_CONFIG, 16'h0001);
        tick(4);
        chk(alarm_code, 16'h0003);
        sam_host_model_i.write(SAM_ADDR_HIST_BASE, 16'hffff);
        rdc(SAM_ADDR_HIST_BASE, 16'h0003);
        sam_host_model_i.write(SAM_ADDR_INT_MASK, 16'h0000);
        tick(2);
        chk({15'h0000, irq}, 16'h0000);
        rdc(8'h40, 16'h0000);
        conclude();
    end
endmodule : sam_regs_bench
